// [src/freezer_ctrl.sv]
// supervisory cycle controller for the batch freezer
`timescale 1ns/1ps
`include "freezer_defines.svh"
module freezer_ctrl
    import freezer_pkg::*;
#(
    parameter longint TIMEOUT_CYC = `TIMEOUT_CYC,
    parameter longint CENTRE_CYC = `CENTRE_CYC,
    parameter longint EXTRACT_DELAY_CYC = `EXTRACT_DELAY_CYC,
    parameter longint BEEP_HALF_CYC = `BEEP_HALF_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic btn_agitation,
    input wire logic btn_stop,
    input wire logic btn_menu,
    input wire logic btn_automatic,
    input wire logic btn_timed,
    input wire logic btn_extraction,
    input wire logic door_open,
    input wire logic grid_lifted,
    input wire logic consistency_min_ok,
    input wire logic product_in_centre,
    input wire logic [`CURRENT_W-1:0] motor_current,
    input wire logic [`CURRENT_W-1:0] current_limit,
    output logic agitator_low,
    output logic agitator_high,
    output logic compressor_on,
    output logic menu_active,
    output logic cycle_done,
    output alarm_t alarm_msg,
    output logic beep
);
    ////////////////////////////////////////////////////////////////////////
    // input synchronisers
    localparam int NIN = 10;
    logic [NIN-1:0] raw_in;
    logic [NIN-1:0] lvl;
    logic [NIN-1:0] rise;
    logic [`CURRENT_W-1:0] cur_meta;
    logic [`CURRENT_W-1:0] cur_s;
    logic [`CURRENT_W-1:0] lim_meta;
    logic [`CURRENT_W-1:0] lim_s;

    assign raw_in = {product_in_centre, consistency_min_ok, grid_lifted, door_open,
                     btn_extraction, btn_timed, btn_automatic, btn_menu,
                     btn_stop, btn_agitation};

    button_sync #(.WIDTH(NIN)) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .raw(raw_in),
        .level(lvl),
        .rise(rise)
    );

    // current is a slow analogue reading, word tearing is tolerated
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cur_meta <= '0;
            cur_s <= '0;
            lim_meta <= '1;
            lim_s <= '1;
        end else if (ce) begin
            cur_meta <= motor_current;
            cur_s <= cur_meta;
            lim_meta <= current_limit;
            lim_s <= lim_meta;
        end
    end

    logic p_agit, p_stop, p_menu, p_auto, p_timed, p_extr;
    logic safety_open, cons_ok, centre;
    assign p_agit = rise[0];
    assign p_stop = rise[1];
    assign p_menu = rise[2];
    assign p_auto = rise[3];
    assign p_timed = rise[4];
    assign p_extr = rise[5];
    assign safety_open = lvl[6] | lvl[7];
    assign cons_ok = lvl[8];
    assign centre = rise[9];

    ////////////////////////////////////////////////////////////////////////
    // mode sequencer
    mode_t mode, next_mode;
    mode_t resume, next_resume;
    alarm_t next_alarm;
    logic [`CYCLE_CNT_W-1:0] batch_cnt, next_batch_cnt;
    logic [`CYCLE_CNT_W-1:0] tmr, next_tmr;
    logic [`BEEP_CNT_W-1:0] beep_cnt, next_beep_cnt;
    logic beep_ph, next_beep_ph;
    logic done, next_done;
    logic batching;
    logic over_limit;

    assign batching = (mode == MODE_AUTO) || (mode == MODE_TIMED) || (mode == MODE_CENTRE);
    assign over_limit = cur_s >= lim_s;

    always_comb begin
        next_mode = mode;
        next_resume = resume;
        next_alarm = alarm_msg;
        next_batch_cnt = batch_cnt;
        next_tmr = tmr;
        next_done = done;
        next_beep_cnt = beep_cnt;
        next_beep_ph = beep_ph;
        if (ce) begin
            if (tmr != '0) begin
                next_tmr = tmr - 1'b1;
            end
            if (batching && !cons_ok) begin
                next_batch_cnt = batch_cnt + 1'b1;
            end
            if (alarm_msg == ALARM_TIMEOUT) begin
                if (beep_cnt >= `BEEP_CNT_W'(BEEP_HALF_CYC - 1)) begin
                    next_beep_cnt = '0;
                    next_beep_ph = ~beep_ph;
                end else begin
                    next_beep_cnt = beep_cnt + 1'b1;
                end
            end
            if (safety_open) begin
                next_mode = MODE_ALARM;
                next_alarm = ALARM_DOOR;
                next_done = 1'b0;
                // door alarm is silent, no beep left stuck high
                next_beep_ph = 1'b0;
                next_beep_cnt = '0;
            end else if (p_stop) begin
                next_mode = MODE_IDLE;
                next_alarm = ALARM_NONE;
                next_done = 1'b0;
                next_beep_ph = 1'b0;
                next_beep_cnt = '0;
            end else if (mode == MODE_ALARM) begin
                next_mode = MODE_ALARM;
            end else if (batching && batch_cnt >= `CYCLE_CNT_W'(TIMEOUT_CYC - 1)) begin
                next_mode = MODE_ALARM;
                next_alarm = ALARM_TIMEOUT;
            end else begin
                unique case (mode)
                    MODE_IDLE, MODE_MENU: begin
                        if (p_agit) begin
                            next_mode = MODE_AGITATE;
                        end else if (p_extr) begin
                            next_mode = MODE_EXTRACT;
                            next_tmr = `CYCLE_CNT_W'(EXTRACT_DELAY_CYC);
                        end else if (p_auto || p_timed) begin
                            next_mode = p_auto ? MODE_AUTO : MODE_TIMED;
                            next_batch_cnt = '0;
                            next_done = 1'b0;
                        end else if (p_menu && mode == MODE_IDLE) begin
                            next_mode = MODE_MENU;
                        end
                    end
                    MODE_AUTO, MODE_TIMED: begin
                        if (p_agit) begin
                            next_mode = MODE_AGITATE;
                        end else if (centre) begin
                            next_resume = mode;
                            next_mode = MODE_CENTRE;
                            next_tmr = `CYCLE_CNT_W'(CENTRE_CYC);
                        end else if (mode == MODE_TIMED && over_limit) begin
                            next_mode = MODE_IDLE;
                            next_done = 1'b1;
                        end
                    end
                    MODE_CENTRE: begin
                        if (p_agit) begin
                            next_mode = MODE_AGITATE;
                        end else if (tmr == `CYCLE_CNT_W'(1)) begin
                            next_mode = resume;
                        end
                    end
                    MODE_EXTRACT: begin
                        if (p_agit) begin
                            next_mode = MODE_AGITATE;
                        end
                    end
                    MODE_AGITATE: begin
                        next_mode = MODE_AGITATE;
                    end
                    MODE_ALARM: begin
                        next_mode = MODE_ALARM;
                    end
                endcase
            end
        end
    end

    // power-on reset always lands in idle, nothing resumes
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode <= MODE_IDLE;
            resume <= MODE_AUTO;
            alarm_msg <= ALARM_NONE;
            batch_cnt <= '0;
            tmr <= '0;
            done <= 1'b0;
            beep_cnt <= '0;
            beep_ph <= 1'b0;
        end else begin
            mode <= next_mode;
            resume <= next_resume;
            alarm_msg <= next_alarm;
            batch_cnt <= next_batch_cnt;
            tmr <= next_tmr;
            done <= next_done;
            beep_cnt <= next_beep_cnt;
            beep_ph <= next_beep_ph;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // motor drive registers
    logic next_ag_low, next_ag_high, next_comp;
    always_comb begin
        next_ag_low = 1'b0;
        next_ag_high = 1'b0;
        next_comp = 1'b0;
        unique case (next_mode)
            MODE_AGITATE: next_ag_low = 1'b1;
            MODE_EXTRACT: begin
                next_ag_high = (next_tmr == '0);
                next_ag_low = (next_tmr != '0);
            end
            MODE_AUTO, MODE_TIMED: begin
                next_ag_low = 1'b1;
                next_comp = 1'b1;
            end
            MODE_CENTRE: next_ag_high = 1'b1;
            default: ; // idle, menu and alarm: all motors off
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            agitator_low <= 1'b0;
            agitator_high <= 1'b0;
            compressor_on <= 1'b0;
        end else if (ce) begin
            agitator_low <= next_ag_low;
            agitator_high <= next_ag_high;
            compressor_on <= next_comp;
        end
    end

    assign menu_active = (mode == MODE_MENU);
    assign cycle_done = done;
    assign beep = beep_ph;

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_door;
        safety_open && ce;
    endsequence

    a_door_stops: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_door |=> (!compressor_on && !agitator_low && !agitator_high
                    && alarm_msg == ALARM_DOOR))
        else $error("door open did not stop machine");
    a_stop_halts: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (p_stop && ce && !safety_open) |=> (!compressor_on && !agitator_low && !agitator_high))
        else $error("stop did not halt motors");
    a_stop_clears_alarm: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (p_stop && ce && !safety_open) |=> (alarm_msg == ALARM_NONE && mode == MODE_IDLE))
        else $error("stop did not clear alarm");
    a_alarm_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (alarm_msg != ALARM_NONE && !p_stop) |=> (alarm_msg != ALARM_NONE))
        else $error("alarm dropped without stop");
    a_centre_fast: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mode == MODE_CENTRE) |-> (!compressor_on && agitator_high))
        else $error("compressor on during centre recovery");
    a_timed_limit: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (ce && mode == MODE_TIMED && over_limit && !safety_open && !p_stop && !p_agit
         && !centre && batch_cnt < `CYCLE_CNT_W'(TIMEOUT_CYC - 1))
        |=> (mode == MODE_IDLE && cycle_done))
        else $error("timed cycle ignored current limit");
    a_agit_no_comp: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mode == MODE_AGITATE && $past(mode) == MODE_AGITATE)
        |-> (!compressor_on && agitator_low))
        else $error("agitation with compressor running");
    a_menu_only_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mode == MODE_MENU) |-> ($past(mode) inside {MODE_IDLE, MODE_MENU}))
        else $error("menu entered while running");
    a_timeout_alarm: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (alarm_msg == ALARM_TIMEOUT) |-> (mode == MODE_ALARM && !compressor_on
                                          && !agitator_low && !agitator_high))
        else $error("timeout alarm without stopped machine");
endmodule : freezer_ctrl

// [inc/freezer_defines.svh]
// constants and timing counts for the batch freezer cycle controller
`ifndef FREEZER_DEFINES_SVH
`define FREEZER_DEFINES_SVH

`define CLK_HZ 25000000
`define TIMEOUT_MIN 35
// product exceeds 32 bits, so the clock rate is widened before multiplying
`define TIMEOUT_CYC (`TIMEOUT_MIN * 60 * longint'(`CLK_HZ))
`define CENTRE_SEC 45
`define CENTRE_CYC (`CENTRE_SEC * `CLK_HZ)
`define EXTRACT_DELAY_SEC 3
`define EXTRACT_DELAY_CYC (`EXTRACT_DELAY_SEC * `CLK_HZ)
`define BEEP_HALF_MS 250
`define BEEP_HALF_CYC (`BEEP_HALF_MS * (`CLK_HZ / 1000))
`define RECIPE_COUNT 24
`define CURRENT_W 12
`define CYCLE_CNT_W 36
`define BEEP_CNT_W 24

`endif

// [inc/freezer_pkg.sv]
// types shared by the batch freezer controller
package freezer_pkg;
    typedef enum logic [1:0] {
        ALARM_NONE,
        ALARM_DOOR,
        ALARM_TIMEOUT
    } alarm_t;
    typedef enum logic [2:0] {
        MODE_IDLE,
        MODE_MENU,
        MODE_AGITATE,
        MODE_EXTRACT,
        MODE_AUTO,
        MODE_TIMED,
        MODE_CENTRE,
        MODE_ALARM
    } mode_t;
endpackage : freezer_pkg

// [src/button_sync.sv]
// two-stage synchroniser and rising-edge pulse for panel and sensor inputs
`timescale 1ns/1ps
module button_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [WIDTH-1:0] raw,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] prev;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_level;
    logic [WIDTH-1:0] next_prev;

    always_comb begin
        next_meta = meta;
        next_level = level;
        next_prev = prev;
        if (ce) begin
            next_meta = raw;
            next_level = meta;
            next_prev = level;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            level <= '0;
            prev <= '0;
        end else begin
            meta <= next_meta;
            level <= next_level;
            prev <= next_prev;
        end
    end

    // edge only from second stage onward, never the first
    assign rise = level & ~prev;
endmodule : button_sync

// [tb/freezer_plant.sv]
// agitator motor and current transformer model on the far side of the controller
`timescale 1ns/1ps
module freezer_plant (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic agitator_low,
    input wire logic agitator_high,
    output logic [11:0] motor_current
);
    // load grows while the product stiffens; collapses to zero once the motor stops
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            motor_current <= 12'h0000;
        end else if (agitator_high) begin
            motor_current <= motor_current + 12'h0002;
        end else if (agitator_low) begin
            motor_current <= motor_current + 12'h0001;
        end else begin
            motor_current <= 12'h0000;
        end
    end
endmodule : freezer_plant

// [tb/batch_freezer_cycle_controller_tb_top.sv]
// self-checking bench for the batch freezer cycle controller
`timescale 1ns/1ps
module batch_freezer_cycle_controller_tb_top
    import freezer_pkg::*;
;
    logic clk_sys;
    logic rst_n;
    logic ce;
    logic [5:0] btn;
    logic [1:0] guard;
    logic consistency_min_ok;
    logic product_in_centre;
    logic [11:0] motor_current;
    logic [11:0] current_limit;
    logic agitator_low;
    logic agitator_high;
    logic compressor_on;
    logic menu_active;
    logic cycle_done;
    alarm_t alarm_msg;
    logic beep;
    int errors;
    int comparisons;
    // button index: 0 agitation, 1 stop, 2 menu, 3 automatic, 4 timed, 5 extraction
    freezer_ctrl #(.TIMEOUT_CYC(200), .CENTRE_CYC(50), .EXTRACT_DELAY_CYC(20),
        .BEEP_HALF_CYC(4)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
        .btn_agitation(btn[0]), .btn_stop(btn[1]), .btn_menu(btn[2]),
        .btn_automatic(btn[3]), .btn_timed(btn[4]), .btn_extraction(btn[5]),
        .door_open(guard[0]), .grid_lifted(guard[1]),
        .consistency_min_ok(consistency_min_ok), .product_in_centre(product_in_centre),
        .motor_current(motor_current), .current_limit(current_limit),
        .agitator_low(agitator_low), .agitator_high(agitator_high),
        .compressor_on(compressor_on), .menu_active(menu_active),
        .cycle_done(cycle_done), .alarm_msg(alarm_msg), .beep(beep)
    );
    freezer_plant plant (
        .clk_sys(clk_sys), .rst_n(rst_n), .agitator_low(agitator_low),
        .agitator_high(agitator_high), .motor_current(motor_current)
    );
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // #1 lets the edge's register updates land before sampling
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : wait_cyc
    task automatic press(input int idx);
        @(posedge clk_sys);
        btn[idx] <= 1'b1;
        repeat (2) @(posedge clk_sys);
        btn[idx] <= 1'b0;
        wait_cyc(8);
    endtask : press
    task automatic motors(input logic low, input logic high, input logic comp);
        check("agitator_low", {11'h000, agitator_low}, {11'h000, low});
        check("agitator_high", {11'h000, agitator_high}, {11'h000, high});
        check("compressor_on", {11'h000, compressor_on}, {11'h000, comp});
    endtask : motors
    task automatic finish_test();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_manual();
        motors(1'b0, 1'b0, 1'b0);
        check("alarm", 12'(alarm_msg), 12'(ALARM_NONE));
        press(0);
        motors(1'b1, 1'b0, 1'b0);
        press(1);
        motors(1'b0, 1'b0, 1'b0);
        press(3);
        motors(1'b1, 1'b0, 1'b1);
        press(2);
        check("menu_refused", {11'h000, menu_active}, 12'h0000);
        press(0);
        motors(1'b1, 1'b0, 1'b0);
        press(1);
        press(2);
        check("menu_active", {11'h000, menu_active}, 12'h0001);
        press(1);
        check("menu_closed", {11'h000, menu_active}, 12'h0000);
        $display("test manual done");
    endtask : test_manual
    task automatic test_extraction();
        press(5);
        motors(1'b1, 1'b0, 1'b0);
        wait_cyc(25);
        check("agitator_high", {11'h000, agitator_high}, 12'h0001);
        press(1);
        $display("test extraction done");
    endtask : test_extraction
    task automatic test_timed();
        @(posedge clk_sys);
        current_limit <= 12'h0040;
        press(4);
        wait_cyc(30);
        check("done_early", {11'h000, cycle_done}, 12'h0000);
        wait_cyc(70);
        check("cycle_done", {11'h000, cycle_done}, 12'h0001);
        check("comp_off", {11'h000, compressor_on}, 12'h0000);
        press(1);
        @(posedge clk_sys);
        current_limit <= 12'h0fff;
        $display("test timed done");
    endtask : test_timed
    task automatic test_timeout();
        int hi;
        hi = 0;
        @(posedge clk_sys);
        consistency_min_ok <= 1'b0;
        press(3);
        wait_cyc(150);
        motors(1'b1, 1'b0, 1'b1);
        wait_cyc(80);
        motors(1'b0, 1'b0, 1'b0);
        check("alarm", 12'(alarm_msg), 12'(ALARM_TIMEOUT));
        for (int i = 0; i < 16; i++) begin
            wait_cyc(1);
            hi += int'(beep === 1'b1);
        end
        check("beep_highs", 12'(hi), 12'h0008);
        press(3);
        check("alarm_held", 12'(alarm_msg), 12'(ALARM_TIMEOUT));
        motors(1'b0, 1'b0, 1'b0);
        press(1);
        check("alarm_clear", 12'(alarm_msg), 12'(ALARM_NONE));
        check("beep_clear", {11'h000, beep}, 12'h0000);
        @(posedge clk_sys);
        consistency_min_ok <= 1'b1;
        $display("test timeout done");
    endtask : test_timeout
    task automatic test_guard();
        for (int g = 0; g < 2; g++) begin
            press(3);
            @(posedge clk_sys);
            guard[g] <= 1'b1;
            wait_cyc(8);
            motors(1'b0, 1'b0, 1'b0);
            check("alarm", 12'(alarm_msg), 12'(ALARM_DOOR));
            @(posedge clk_sys);
            guard[g] <= 1'b0;
            press(3);
            check("alarm_held", 12'(alarm_msg), 12'(ALARM_DOOR));
            motors(1'b0, 1'b0, 1'b0);
            press(1);
            check("alarm_clear", 12'(alarm_msg), 12'(ALARM_NONE));
        end
        $display("test guard done");
    endtask : test_guard
    task automatic test_centre();
        press(3);
        @(posedge clk_sys);
        product_in_centre <= 1'b1;
        wait_cyc(8);
        motors(1'b0, 1'b1, 1'b0);
        @(posedge clk_sys);
        product_in_centre <= 1'b0;
        wait_cyc(60);
        motors(1'b1, 1'b0, 1'b1);
        press(1);
        $display("test centre done");
    endtask : test_centre
    // a press while the enable is low is lost, not queued
    task automatic test_freeze();
        press(3);
        motors(1'b1, 1'b0, 1'b1);
        @(posedge clk_sys);
        ce <= 1'b0;
        press(1);
        motors(1'b1, 1'b0, 1'b1);
        @(posedge clk_sys);
        ce <= 1'b1;
        press(1);
        motors(1'b0, 1'b0, 1'b0);
        $display("test freeze done");
    endtask : test_freeze
    task automatic test_power_loss();
        press(3);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        wait_cyc(20);
        motors(1'b0, 1'b0, 1'b0);
        check("alarm", 12'(alarm_msg), 12'(ALARM_NONE));
        press(3);
        motors(1'b1, 1'b0, 1'b1);
        press(1);
        motors(1'b0, 1'b0, 1'b0);
        $display("test power loss done");
    endtask : test_power_loss
    ////////////////////////////////////////////////////////////////////////////////
    // whole run is near 830 cycles; the limit leaves wide margin
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        $display("mismatch watchdog expected done seen hang");
        finish_test();
    end
    initial begin
        errors = 0;
        comparisons = 0;
        rst_n = 1'b0;
        ce = 1'b1;
        btn = 6'h00;
        guard = 2'h0;
        consistency_min_ok = 1'b1;
        product_in_centre = 1'b0;
        current_limit = 12'h0fff;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        wait_cyc(2);
        test_manual();
        test_extraction();
        test_timed();
        test_timeout();
        test_guard();
        test_centre();
        test_freeze();
        test_power_loss();
        finish_test();
    end
endmodule : batch_freezer_cycle_controller_tb_top
